// ---- common/lsem_pkg.sv ----
// constants, modes and timing for the load shed energy manager
// assumes a single 20 MHz clock; current values are whole amps
package lsem_pkg;
	localparam int LSEM_CLK_HZ = 20_000_000;
	localparam int LSEM_TICK_S = 1;
	localparam int LSEM_TICK_CYC = LSEM_CLK_HZ * LSEM_TICK_S;
	localparam int LSEM_HOLD_S = 120;
	localparam int LSEM_FLASH_MS = 500;
	localparam int LSEM_FLASH_CYC = LSEM_CLK_HZ / 1000 * LSEM_FLASH_MS;
	localparam int LSEM_MSG_MS = 100;
	localparam int LSEM_MSG_CYC = LSEM_CLK_HZ / 1000 * LSEM_MSG_MS;
	localparam int LSEM_NLOAD = 6;
	localparam logic [7:0] LSEM_LIM_30 = 8'h1e;
	localparam logic [7:0] LSEM_LIM_20 = 8'h14;
	localparam logic [7:0] LSEM_LIM_GEN_LO = 8'h2d;
	localparam logic [7:0] LSEM_LIM_GEN_HI = 8'h3c;
	localparam logic [7:0] LSEM_HOLD_SEC = 8'h78;
	localparam logic [7:0] LSEM_METER_MAX = 8'h63;
	localparam logic [5:0] LSEM_ALL_ON = 6'h3f;
	// service lamp bit positions
	localparam int LSEM_SVC_50 = 0;
	localparam int LSEM_SVC_GEN = 1;
	localparam int LSEM_SVC_30 = 2;
	localparam int LSEM_SVC_20 = 3;
	typedef enum logic [3:0] {
		LSEM_SRC_NONE = 4'b0001,
		LSEM_SRC_50 = 4'b0010,
		LSEM_SRC_GEN = 4'b0100,
		LSEM_SRC_SHORE = 4'b1000
	} lsem_src_t;
endpackage

// ---- rtl/lsem_msg.sv ----
// periodic display message framer toward the remote panel
// assumes a downstream serialiser takes the word on each strobe
`timescale 1ns/100ps
module lsem_msg
	import lsem_pkg::*;
#(
	parameter int PERIOD_CYC = LSEM_MSG_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// display state
	input wire logic [7:0] meter_i,
	input wire logic meter_blank_i,
	input wire logic [5:0] load_lamp_i,
	input wire logic [3:0] svc_lamp_i,
	// message out
	output logic [19:0] msg_o,
	output logic msg_stb_o
);
	// ==========================================
	// period counter
	logic [31:0] cnt_reg;
	wire cnt_end = (cnt_reg == 32'(PERIOD_CYC - 1));
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cnt_reg <= '0;
			msg_stb_o <= 1'b0;
			msg_o <= '0;
		end else begin
			cnt_reg <= cnt_end ? '0 : cnt_reg + 32'h1;
			msg_stb_o <= cnt_end;
			if (cnt_end) begin
				msg_o <= {svc_lamp_i, load_lamp_i, meter_blank_i, meter_i[6:0], 2'h0};
			end
		end
	end
endmodule

// ---- rtl/lsem_top.sv ----
// load shed energy manager core: source detect, shed and restore of six loads
// assumes line/generator/button pins are asynchronous; current is sampled amps
// Function
// - on 240 V service, management off and every relay closed.
// - in 50 A mode blank meter, light 50 A lamp and all load lamps.
// - 240 V between lines selects 50 A mode even with generator running.
// - generator run with equal lines gives generator mode, meter and gen lamp.
// - generator limiting off (default) turns on all loads and lamps.
// - single phase without generator run means 30 A shore, management on.
// - new shore power starts in 30 A mode; 30/20 lamp lit in 30 A.
// - button press toggles the shore limit between 20 A and 30 A.
// - without 240 V, current over active limit sheds controlled loads.
// - management starts loads one at a time, one second apart.
// - over limit, shed one load at a time in table order until fixed.
// - on each shed, store current drop as that load's learned value.
// - restore last shed load only when spare current covers learned value.
// - a shed load stays off at least two minutes.
// - during hold-off flash lamp if current available, then energise steadily.
// - six relay outputs, four line loads, two low-voltage circuits.
// - lamps follow powered loads; meter shows current in single phase.
// - four service lamps, one per source, 20 A chosen by operator.
// - generator limit switch on disables management, meter still shown.
// - with generator limiting, rating switch gives 45 A on, 60 A off.
`timescale 1ns/100ps
module lsem_top
	import lsem_pkg::*;
#(
	parameter int TICK_CYC = LSEM_TICK_CYC,
	parameter int FLASH_CYC = LSEM_FLASH_CYC,
	parameter int MSG_CYC = LSEM_MSG_CYC,
	parameter logic [7:0] HOLD_SEC = LSEM_HOLD_SEC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// line sense pins
	input wire logic line_one_input_i,
	input wire logic line_two_input_i,
	input wire logic line_240_i,
	input wire logic generator_run_sense_i,
	// configuration switches
	input wire logic generator_limit_disable_switch_i,
	input wire logic generator_rating_switch_i,
	input wire logic [2:0] shed_order_sel_i,
	input wire logic service_select_btn_i,
	// current sensor, amps
	input wire logic [7:0] neutral_amps_i,
	// relays and lamps
	output logic [5:0] relay_o,
	output logic [5:0] load_lamp_o,
	output logic [3:0] svc_lamp_o,
	output logic [7:0] meter_o,
	output logic meter_blank_o,
	output logic link_good_lamp_o,
	output logic link_fault_lamp_o,
	// panel message
	output logic [19:0] msg_o,
	output logic msg_stb_o
);
	// ==========================================
	// pin synchronisers
	logic [5:0] s1_reg, s2_reg;
	logic [7:0] amp1_reg, amp2_reg, amp3_reg, amp_reg;
	// the sensor word is not gray coded: a reading is taken only once two
	// synchronised samples agree, so a word caught mid-change is never used
	wire amp_same = (amp3_reg == amp2_reg);
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			amp1_reg <= '0;
			amp2_reg <= '0;
			amp3_reg <= '0;
			amp_reg <= '0;
		end else begin
			s1_reg <= {service_select_btn_i, generator_rating_switch_i,
				generator_limit_disable_switch_i, generator_run_sense_i,
				line_240_i, line_one_input_i | line_two_input_i};
			s2_reg <= s1_reg;
			amp1_reg <= neutral_amps_i;
			amp2_reg <= amp1_reg;
			amp3_reg <= amp2_reg;
			if (amp_same) begin
				amp_reg <= amp3_reg;
			end
		end
	end
	wire line_on = s2_reg[0];
	wire l240 = s2_reg[1];
	wire gen_run = s2_reg[2];
	wire gen_lim_off = s2_reg[3];
	wire gen_rate = s2_reg[4];
	wire btn = s2_reg[5];

	// ==========================================
	// source detection
	lsem_src_t src;
	assign src = !line_on ? LSEM_SRC_NONE :
		l240 ? LSEM_SRC_50 :
		gen_run ? LSEM_SRC_GEN :
		LSEM_SRC_SHORE;
	lsem_src_t src_reg;
	logic lim20_reg, btn_reg;
	wire btn_rise = btn & ~btn_reg;
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			src_reg <= LSEM_SRC_NONE;
			lim20_reg <= 1'b0;
			btn_reg <= 1'b0;
		end else begin
			src_reg <= src;
			btn_reg <= btn;
			if (src == LSEM_SRC_SHORE && src_reg != LSEM_SRC_SHORE) begin
				lim20_reg <= 1'b0;
			end else if (src == LSEM_SRC_SHORE && btn_rise) begin
				lim20_reg <= ~lim20_reg;
			end
		end
	end
	wire manage = (src_reg == LSEM_SRC_SHORE) ||
		(src_reg == LSEM_SRC_GEN && !gen_lim_off);
	wire [7:0] gen_lim = gen_rate ? LSEM_LIM_GEN_LO : LSEM_LIM_GEN_HI;
	wire [7:0] limit = (src_reg == LSEM_SRC_GEN) ? gen_lim :
		lim20_reg ? LSEM_LIM_20 : LSEM_LIM_30;
	wire over = amp_reg > limit;
	// difference floored at zero; a reading that rose while a load was
	// shed must not wrap into a huge learned value that blocks its restore
	function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
		sat_sub = (a > b) ? a - b : 8'h00;
	endfunction
	wire [7:0] spare = sat_sub(limit, amp_reg);

	// ==========================================
	// time base: one second tick and flash toggle
	logic [31:0] tick_cnt_reg, flash_cnt_reg;
	logic tick_reg, flash_reg;
	// wrap on the last count so a tick comes every TICK_CYC cycles, not one more
	wire tick_end = (tick_cnt_reg == 32'(TICK_CYC - 1));
	// the flash phase runs free, so a pending lamp may start mid-phase
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			tick_cnt_reg <= '0;
			flash_cnt_reg <= '0;
			tick_reg <= 1'b0;
			flash_reg <= 1'b0;
		end else begin
			tick_reg <= tick_end;
			tick_cnt_reg <= tick_end ? '0 : tick_cnt_reg + 32'h1;
			if (flash_cnt_reg == 32'(FLASH_CYC - 1)) begin
				flash_cnt_reg <= '0;
				flash_reg <= ~flash_reg;
			end else begin
				flash_cnt_reg <= flash_cnt_reg + 32'h1;
			end
		end
	end

	// ==========================================
	// shed table: eight wirings of relay shed order
	function automatic logic [17:0] order_of(input logic [2:0] sel);
		// six 3-bit relay indices, first shed in the top bits
		unique case (sel)
			3'h0: order_of = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
			3'h1: order_of = {3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
			3'h2: order_of = {3'h3, 3'h2, 3'h5, 3'h4, 3'h1, 3'h0};
			3'h3: order_of = {3'h3, 3'h2, 3'h1, 3'h5, 3'h4, 3'h0};
			3'h4: order_of = {3'h3, 3'h2, 3'h1, 3'h0, 3'h5, 3'h4};
			3'h5: order_of = {3'h5, 3'h3, 3'h4, 3'h2, 3'h1, 3'h0};
			3'h6: order_of = {3'h3, 3'h5, 3'h2, 3'h4, 3'h1, 3'h0};
			default: order_of = {3'h3, 3'h2, 3'h5, 3'h1, 3'h4, 3'h0};
		endcase
	endfunction
	// switches read closed as one; column one is all switches on
	logic [2:0] cfg1_reg, cfg2_reg;
	wire [17:0] order = order_of(~cfg2_reg);
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			cfg1_reg <= '1;
			cfg2_reg <= '1;
		end else begin
			// the switches are pins like any other and pass two flops
			cfg1_reg <= shed_order_sel_i;
			cfg2_reg <= cfg1_reg;
		end
	end
	function automatic logic [2:0] relay_at(input logic [17:0] ord, input logic [2:0] pos);
		relay_at = ord[17 - 3 * pos -: 3];
	endfunction

	// ==========================================
	// load engine
	// shed_cnt counts loads currently shed, stacked in table order, so the
	// most recently shed load is always the one restored first
	logic [5:0] on_reg;
	logic [2:0] shed_cnt_reg;
	logic [2:0] start_cnt_reg;
	logic [7:0] learn_reg [LSEM_NLOAD];
	logic [7:0] hold_reg;
	logic [7:0] pre_amp_reg;
	logic learn_pend_reg;
	logic [2:0] last_rel_reg;
	wire [2:0] shed_rel = relay_at(order, shed_cnt_reg);
	wire [2:0] rest_rel = relay_at(order, shed_cnt_reg - 3'h1);
	wire [2:0] start_rel = relay_at(order, 3'h5 - start_cnt_reg);
	wire can_restore = !over && (spare >= learn_reg[rest_rel]);
	wire starting = start_cnt_reg != 3'(LSEM_NLOAD);
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			on_reg <= '0;
			shed_cnt_reg <= '0;
			start_cnt_reg <= '0;
			hold_reg <= '0;
			pre_amp_reg <= '0;
			learn_pend_reg <= 1'b0;
			last_rel_reg <= '0;
			for (int i = 0; i < LSEM_NLOAD; i++) begin
				learn_reg[i] <= '0;
			end
		end else if (!manage) begin
			if (src_reg == LSEM_SRC_NONE) begin
				on_reg <= '0;
			end else begin
				on_reg <= LSEM_ALL_ON;
			end
			shed_cnt_reg <= '0;
			start_cnt_reg <= '0;
			hold_reg <= '0;
			learn_pend_reg <= 1'b0;
		end else if (tick_reg) begin
			// one action per tick, learning first: each measured drop then
			// belongs to exactly one relay
			if (hold_reg != 8'h00) begin
				hold_reg <= hold_reg - 8'h01;
			end
			if (learn_pend_reg) begin
				learn_reg[last_rel_reg] <= sat_sub(pre_amp_reg, amp_reg);
				learn_pend_reg <= 1'b0;
			end else if (over && shed_cnt_reg != 3'(LSEM_NLOAD)) begin
				// a load is judged one tick after it is shed so the sensor settles
				pre_amp_reg <= amp_reg;
				on_reg[shed_rel] <= 1'b0;
				last_rel_reg <= shed_rel;
				shed_cnt_reg <= shed_cnt_reg + 3'h1;
				learn_pend_reg <= 1'b1;
				hold_reg <= HOLD_SEC;
				if (starting) begin
					start_cnt_reg <= 3'(LSEM_NLOAD);
				end
			end else if (starting) begin
				on_reg[start_rel] <= 1'b1;
				start_cnt_reg <= start_cnt_reg + 3'h1;
			end else if (shed_cnt_reg != 3'h0 && hold_reg == 8'h00 && can_restore) begin
				on_reg[rest_rel] <= 1'b1;
				shed_cnt_reg <= shed_cnt_reg - 3'h1;
			end
		end
	end
	// only the load that would come back next flashes, while its hold-off runs
	wire [5:0] pend_flash = (shed_cnt_reg != 3'h0 && hold_reg != 8'h00 && can_restore)
		? (6'h01 << rest_rel) : 6'h00;

	// ==========================================
	// outputs
	wire single = (src_reg == LSEM_SRC_GEN) || (src_reg == LSEM_SRC_SHORE);
	wire [3:0] svc = {(src_reg == LSEM_SRC_SHORE) && lim20_reg,
		(src_reg == LSEM_SRC_SHORE) && !lim20_reg,
		src_reg == LSEM_SRC_GEN, src_reg == LSEM_SRC_50};
	wire [7:0] meter = (amp_reg > LSEM_METER_MAX) ? LSEM_METER_MAX : amp_reg;
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			relay_o <= '0;
			load_lamp_o <= '0;
			svc_lamp_o <= '0;
			meter_o <= '0;
			meter_blank_o <= 1'b1;
			link_good_lamp_o <= 1'b0;
			link_fault_lamp_o <= 1'b0;
		end else begin
			relay_o <= on_reg;
			load_lamp_o <= on_reg | (pend_flash & {6{flash_reg}});
			svc_lamp_o <= svc;
			meter_o <= single ? meter : 8'h00;
			meter_blank_o <= !single;
			link_good_lamp_o <= 1'b1;
			link_fault_lamp_o <= 1'b0;
		end
	end

	lsem_msg #(
		.PERIOD_CYC(MSG_CYC)
	) u_msg (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.meter_i(meter_o),
		.meter_blank_i(meter_blank_o),
		.load_lamp_i(load_lamp_o),
		.svc_lamp_i(svc_lamp_o),
		.msg_o(msg_o),
		.msg_stb_o(msg_stb_o)
	);
endmodule

// ---- sim/lsem_load_model.sv ----
// partner model: six loads behind the relays and the neutral sensor
// assumes every closed relay draws load_amps_i on top of base_amps_i
`timescale 1ns/100ps
module lsem_load_model (
	// clock
	input wire logic mclk_i,
	// loads
	input wire logic [5:0] relay_i,
	input wire logic [7:0] load_amps_i,
	input wire logic [7:0] base_amps_i,
	// sensor
	output logic [7:0] neutral_amps_o
);
	// ==========
	// sensor
	// registered so the reading changes just after an edge, as a real sensor lags
	always_ff @(posedge mclk_i) begin
		neutral_amps_o <= base_amps_i + load_amps_i * 8'($countones(relay_i));
	end
endmodule

// ---- sim/lsem_top_bench.sv ----
// self-checking bench for lsem_top with a load and sensor model
// assumes shortened tick, flash, message and hold counts
`timescale 1ns/100ps
module lsem_top_bench;
	import lsem_pkg::*;
	localparam int TK = 20;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic l1 = 1'b0, l2 = 1'b0, l240 = 1'b0, gen = 1'b0, gdis = 1'b0, grat = 1'b0, btn = 1'b0;
	logic [7:0] la = 8'h00, ba = 8'h00;
	logic [7:0] amps, meter;
	logic [5:0] relay, lamp;
	logic [3:0] svc;
	logic blank, good, bad;
	logic stb;
	logic [19:0] msg;
	logic [2:0] sel = 3'h7;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	// ==========
	lsem_top #(.TICK_CYC(TK), .FLASH_CYC(4), .MSG_CYC(16), .HOLD_SEC(8'h03)) u_lsem_top (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .line_one_input_i(l1), .line_two_input_i(l2),
		.line_240_i(l240), .generator_run_sense_i(gen), .generator_limit_disable_switch_i(gdis),
		.generator_rating_switch_i(grat), .shed_order_sel_i(sel), .service_select_btn_i(btn),
		.neutral_amps_i(amps), .relay_o(relay), .load_lamp_o(lamp), .svc_lamp_o(svc),
		.meter_o(meter), .meter_blank_o(blank), .link_good_lamp_o(good),
		.link_fault_lamp_o(bad), .msg_o(msg), .msg_stb_o(stb));
	lsem_load_model u_lsem_load_model (.mclk_i(mclk_i), .relay_i(relay), .load_amps_i(la),
		.base_amps_i(ba), .neutral_amps_o(amps));
	initial forever #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// waits are bounded; a miss shows up in the compare that follows
	task automatic wait_relay(input logic [5:0] exp);
		for (int i = 0; i < 40 * TK && relay !== exp; i++) @(negedge mclk_i);
	endtask
	task automatic start(input logic [5:0] pins, input logic [7:0] a, input logic [7:0] b);
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		{l1, l2, l240, gen, gdis, grat} <= pins;
		la <= a;
		ba <= b;
		repeat (3) @(posedge mclk_i);
		rstn_i <= 1'b1;
	endtask
	task automatic press();
		@(posedge mclk_i);
		btn <= 1'b1;
		repeat (4) @(posedge mclk_i);
		btn <= 1'b0;
		repeat (6) @(negedge mclk_i);
	endtask
	initial begin
		// split phase with the generator also running
		start(6'h3c, 8'h0a, 8'h05);
		wait_relay(LSEM_ALL_ON);
		chk({2'h0, relay}, 8'h3f);
		chk({blank, 1'b0, lamp}, 8'hbf);
		chk({blank, 3'h0, svc}, 8'h81);
		press();
		chk({good, bad, 2'h0, svc}, 8'h81);
		for (int i = 0; i < 64 && stb !== 1'b1; i++) @(negedge mclk_i);
		chk(msg[19:12], 8'h1f);
		chk(msg[11:4], 8'he0);
		chk({4'h0, msg[3:0]}, 8'h00);
		$display("split phase done");
		// generator, limiting off: 5 + 6 x 10 amps
		start(6'h36, 8'h0a, 8'h05);
		wait_relay(LSEM_ALL_ON);
		repeat (8) @(negedge mclk_i);
		chk({2'h0, relay}, 8'h3f);
		chk({blank, 3'h0, svc}, 8'h02);
		chk(meter, 8'h41);
		$display("generator free done");
		// generator limited: 45 A with 7 A loads, 60 A with 10 A loads
		// the 45 A pass uses shed column two, whose first shed is relay four
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk_i);
			sel <= k[0] ? 3'h6 : 3'h7;
			start({5'h1a, k[0]}, k[0] ? 8'h07 : 8'h0a, 8'h05);
			wait_relay(LSEM_ALL_ON);
			wait_relay(k[0] ? 6'h37 : 6'h1f);
			repeat (8) @(negedge mclk_i);
			chk({2'h0, relay}, k[0] ? 8'h37 : 8'h1f);
			chk(meter, k[0] ? 8'h28 : 8'h37);
		end
		@(posedge mclk_i);
		sel <= 3'h7;
		$display("generator limited done");
		// shore: 2 + 6 x 5 = 32 sheds load six, spare 3 is short of 5
		start(6'h30, 8'h05, 8'h02);
		wait_relay(LSEM_ALL_ON);
		wait_relay(6'h1f);
		chk({blank, 3'h0, svc}, 8'h04);
		repeat (2 * TK) @(negedge mclk_i);
		chk({2'h0, relay}, 8'h1f);
		@(posedge mclk_i);
		ba <= 8'h00;
		wait_relay(LSEM_ALL_ON);
		repeat (8) @(negedge mclk_i);
		chk({2'h0, lamp}, 8'h3f);
		$display("shore restore done");
		// 20 A: 30 sheds six then five, leaving 20
		press();
		chk({blank, 3'h0, svc}, 8'h08);
		wait_relay(6'h0f);
		chk({2'h0, relay}, 8'h0f);
		press();
		chk({blank, 3'h0, svc}, 8'h04);
		$display("shore 20 A done");
		close_out();
	end
endmodule

// ---- sim/lsem_top_props.sv ----
// checker on the ports of lsem_top
// assumes the shortened counts handed on by the bind
`timescale 1ns/100ps
module lsem_top_props
	import lsem_pkg::*;
#(
	parameter int TICK_CYC = 20,
	parameter int MSG_CYC = 16,
	parameter logic [7:0] HOLD_SEC = 8'h03
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// pins
	input wire logic line_240_i,
	input wire logic generator_run_sense_i,
	input wire logic generator_limit_disable_switch_i,
	input wire logic service_select_btn_i,
	// outputs
	input wire logic [5:0] relay_o,
	input wire logic [5:0] load_lamp_o,
	input wire logic [3:0] svc_lamp_o,
	input wire logic meter_blank_o,
	input wire logic msg_stb_o
);
	localparam int MSG_M1 = MSG_CYC - 1;
	localparam int HOLD_M1 = HOLD_SEC * TICK_CYC - 1;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// ==========
	// one counter suffices: only the last shed load may come back
	logic [5:0] prev_reg;
	logic [15:0] fall_cnt_reg;
	wire logic gen_w = generator_run_sense_i & !line_240_i;
	wire logic mgd_w = (svc_lamp_o[3:1] != 3'h0) & !generator_limit_disable_switch_i;
	wire logic up_w = |(relay_o & ~prev_reg);
	wire logic fell_w = |(prev_reg & ~relay_o);
	wire logic [15:0] fall_cnt_next = fell_w ? 16'h0000 : fall_cnt_reg + {15'h0000, ~&fall_cnt_reg};
	always_ff @(posedge mclk_i) begin
		prev_reg <= relay_o;
		fall_cnt_reg <= rstn_i ? fall_cnt_next : 16'hffff;
	end
	property p_full; line_240_i [*8] |-> relay_o == LSEM_ALL_ON; endproperty
	a_full: assert property (p_full) else $error("relay open on 240 V");
	property p_blank;
		line_240_i [*8] |-> meter_blank_o && svc_lamp_o == 4'h1 && load_lamp_o == LSEM_ALL_ON;
	endproperty
	a_blank: assert property (p_blank) else $error("split phase display wrong");
	property p_gen; gen_w [*8] |-> svc_lamp_o == 4'h2 && !meter_blank_o; endproperty
	a_gen: assert property (p_gen) else $error("generator display wrong");
	property p_genall;
		(gen_w && generator_limit_disable_switch_i) [*8] |-> relay_o == LSEM_ALL_ON;
	endproperty
	a_genall: assert property (p_genall) else $error("generator load off");
	property p_first; $rose(|svc_lamp_o[3:2]) |-> svc_lamp_o[LSEM_SVC_30]; endproperty
	a_first: assert property (p_first) else $error("shore not in 30 A");
	property p_btn;
		$rose(service_select_btn_i) && svc_lamp_o[LSEM_SVC_30] |-> ##[1:8] svc_lamp_o[LSEM_SVC_20];
	endproperty
	a_btn: assert property (p_btn) else $error("press did not select 20 A");
	property p_one; mgd_w |-> $countones($past(relay_o) & ~relay_o) <= 1; endproperty
	a_one: assert property (p_one) else $error("two loads shed at once");
	property p_hold; mgd_w && up_w |-> fall_cnt_reg >= HOLD_M1; endproperty
	a_hold: assert property (p_hold) else $error("load back too soon");
	property p_msg; msg_stb_o |=> !msg_stb_o ##MSG_M1 msg_stb_o; endproperty
	a_msg: assert property (p_msg) else $error("message period wrong");
	c_shed: cover property (mgd_w && fell_w);
	c_both: cover property (line_240_i && generator_run_sense_i);
	c_btn: cover property ($rose(service_select_btn_i) && svc_lamp_o[LSEM_SVC_30]);
endmodule
bind lsem_top lsem_top_props #(.TICK_CYC(TICK_CYC), .MSG_CYC(MSG_CYC), .HOLD_SEC(HOLD_SEC))
	u_lsem_top_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .line_240_i(line_240_i),
	.generator_run_sense_i(generator_run_sense_i),
	.generator_limit_disable_switch_i(generator_limit_disable_switch_i),
	.service_select_btn_i(service_select_btn_i), .relay_o(relay_o), .load_lamp_o(load_lamp_o),
	.svc_lamp_o(svc_lamp_o), .meter_blank_o(meter_blank_o), .msg_stb_o(msg_stb_o));
